/* File: core/dea_pkg.sv */
// Constants, register map and state types of the data store access controller.
package dea_pkg;

  // Register indices; byte address is four times the index.
  localparam logic [7:0]  IDX_BYTE      = 8'h9A;
  localparam logic [7:0]  IDX_LOC       = 8'h9B;
  localparam logic [7:0]  IDX_CTRL      = 8'h9C;
  localparam logic [7:0]  IDX_KEY       = 8'h9D;
  localparam logic [7:0]  IDX_FLAG      = 8'h9E;
  localparam int unsigned ADDR_W        = 12;
  localparam logic [11:0] ADDR_BYTE     = {2'h0, IDX_BYTE, 2'h0};
  localparam logic [11:0] ADDR_LOC      = {2'h0, IDX_LOC, 2'h0};
  localparam logic [11:0] ADDR_CTRL     = {2'h0, IDX_CTRL, 2'h0};
  localparam logic [11:0] ADDR_KEY      = {2'h0, IDX_KEY, 2'h0};
  localparam logic [11:0] ADDR_FLAG     = {2'h0, IDX_FLAG, 2'h0};

  // Field positions of the control and flag registers.
  localparam int unsigned CTRL_RD       = 0;
  localparam int unsigned CTRL_WR       = 1;
  localparam int unsigned CTRL_PERMIT   = 2;
  localparam int unsigned CTRL_ABORT    = 3;
  localparam int unsigned FLAG_DONE     = 0;

  // Unlock keys.
  localparam logic [7:0]  KEY_FIRST     = 8'h55;
  localparam logic [7:0]  KEY_SECOND    = 8'hAA;

  // Timing: clock period, longest gap between unlock steps, array store time.
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned KEY_GAP_NS    = 400;
  localparam int unsigned KEY_GAP_CYC   = KEY_GAP_NS / CLK_PERIOD_NS;
  localparam int unsigned STORE_TIME_NS = 4000000;
  localparam int unsigned STORE_CYC     = STORE_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned CNT_W         = 20;
  localparam int unsigned GAP_W         = 4;

  // Bus answers.
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // Unlock tracker states.
  typedef enum logic [1:0] {DEA_LK_IDLE, DEA_LK_KEY1, DEA_LK_KEY2} dea_lock_t;

  // Whole state of the controller except the data store array.
  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic              aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_held;
    logic [7:0]        w_data;
    logic              w_lane;
    logic [7:0]        byte_reg;
    logic [7:0]        loc_reg;
    logic              rd;
    logic              wr;
    logic              permit;
    logic              abort;
    logic              done;
    dea_lock_t         lock;
    logic [GAP_W-1:0]  gap;
    logic [CNT_W-1:0]  store_cnt;
    logic [7:0]        st_loc;
    logic [7:0]        st_byte;
  } dea_state_t;

endpackage : dea_pkg

/* File: core/dea_ctrl.sv */
// AXI4-Lite access controller for the on-chip data store array.
//
// Notes on behaviour
// [R1] Software loads location, then sets read trigger.
// [R2] Addressed byte lands in byte register next cycle.
// [R3] Read takes one cycle; hardware clears trigger.
// [R4] Writing one starts read; zero ignored.
// [R5] Byte register holds until read or write.
// [R6] Software loads location and byte before unlock.
// [R7] Store needs 55h, AAh, then start bit.
// [R8] Broken unlock order starts no store.
// [R9] Unlock steps outside the cycle window fail.
// [R10] Start bit settable only with permit set.
// [R11] Permit bit changed by software only; warm reset here also clears it.
// [R12] Clearing permit never aborts running store.
// [R13] Store end clears start, sets done flag.
// [R14] Software clears done flag itself.
// [R15] Software masks interrupts around unlock sequence.
// [R16] Software keeps permit clear except while storing.
// [R17] Software verifies stored bytes by read back.
// [R18] Software cannot clear start bit early.
// [R19] Warm reset during store sets abort, keeps registers.
// [R20] Key port has no storage, reads zero.
// [R21] Any other access returns tracker to idle.
//
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/10ps
module dea_ctrl #(
  parameter int unsigned STORE_CYCLES = dea_pkg::STORE_CYC,  // Array store duration in clock cycles.
  parameter int unsigned DEPTH        = 256                   // Number of bytes in the array.
) (
  // Clock and the two resets.
  input  logic                       core_clk,
  input  logic                       rst,
  input  logic                       warm_rst,
  // Write address channel.
  input  logic                       s_axi_awvalid,
  output logic                       s_axi_awready,
  input  logic [dea_pkg::ADDR_W-1:0] s_axi_awaddr,
  // Write data channel.
  input  logic                       s_axi_wvalid,
  output logic                       s_axi_wready,
  input  logic [31:0]                s_axi_wdata,
  input  logic [3:0]                 s_axi_wstrb,
  // Write response channel.
  output logic                       s_axi_bvalid,
  input  logic                       s_axi_bready,
  output logic [1:0]                 s_axi_bresp,
  // Read address channel.
  input  logic                       s_axi_arvalid,
  output logic                       s_axi_arready,
  input  logic [dea_pkg::ADDR_W-1:0] s_axi_araddr,
  // Read data channel.
  output logic                       s_axi_rvalid,
  input  logic                       s_axi_rready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  // Store in progress, straight from the start bit.
  output logic                       store_busy
);

  // Registered state and its next value.
  dea_pkg::dea_state_t st_ff;
  dea_pkg::dea_state_t nxt_st;

  // The data store array itself.
  logic [7:0] mem_q [0:DEPTH-1];

  // Byte currently addressed by the location register.
  logic [7:0] mem_rd;
  // Array write strobe at the end of a store.
  logic       mem_we;
  // Register write taken this cycle, and the read address taken this cycle.
  logic       wr_go;
  logic       ar_go;
  // Control register written with the read trigger set.
  logic       ctl_rd_go;

  // Store count as a typed constant of the counter's width.
  localparam logic [dea_pkg::CNT_W-1:0] STORE_LOAD = dea_pkg::CNT_W'(STORE_CYCLES);
  localparam logic [dea_pkg::GAP_W-1:0] GAP_LAST   = dea_pkg::GAP_W'(dea_pkg::KEY_GAP_CYC - 1);

  // Fetch path: the array is read combinationally at the location register.
  assign mem_rd = mem_q[st_ff.loc_reg];

  // Next-state logic of the whole controller.
  always_comb begin
    // Hold every field by default; strobes default low.
    nxt_st    = st_ff;
    mem_we    = 1'b0;
    ctl_rd_go = 1'b0;
    // A register write fires once both halves are held and no answer waits.
    wr_go     = st_ff.aw_held && st_ff.w_held && !st_ff.bvalid;
    // A read address is taken whenever the slave shows ready.
    ar_go     = s_axi_arvalid && st_ff.arready;

    // Write address and data are taken separately and held.
    if (s_axi_awvalid && st_ff.awready) begin
      nxt_st.aw_held = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    // Only byte lane 0 is kept, since every register is eight bits wide.
    if (s_axi_wvalid && st_ff.wready) begin
      nxt_st.w_held = 1'b1;
      nxt_st.w_data = s_axi_wdata[7:0];
      nxt_st.w_lane = s_axi_wstrb[0];
    end
    // The response is released once the master takes it.
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    // The read answer likewise clears once rready is seen.
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end

    // The unlock window closes after the longest allowed gap.
    // The gap counter only runs while the tracker is part way through.
    if (st_ff.lock != dea_pkg::DEA_LK_IDLE) begin
      nxt_st.gap = st_ff.gap + 1'b1;
      // [R9] Late unlock step fails.
      if (st_ff.gap == GAP_LAST) begin
        nxt_st.lock = dea_pkg::DEA_LK_IDLE;
      end
    end

    // Register read: answer is registered one cycle after the address.
    if (ar_go) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp  = dea_pkg::RESP_OKAY;
      // Unused upper bits of every register read as zero.
      nxt_st.rdata  = 32'h0000_0000;
      // [R21] Reads also cancel unlock.
      nxt_st.lock   = dea_pkg::DEA_LK_IDLE;
      case (s_axi_araddr)
        dea_pkg::ADDR_BYTE: nxt_st.rdata[7:0] = st_ff.byte_reg;
        dea_pkg::ADDR_LOC:  nxt_st.rdata[7:0] = st_ff.loc_reg;
        // Upper four control bits read as zero.
        dea_pkg::ADDR_CTRL: nxt_st.rdata[3:0] = {st_ff.abort, st_ff.permit, st_ff.wr, st_ff.rd};
        // [R20] Key port reads zero.
        dea_pkg::ADDR_KEY:  nxt_st.rdata      = 32'h0000_0000;
        dea_pkg::ADDR_FLAG: nxt_st.rdata[0]   = st_ff.done;
        // Unmapped read: error answer with zero data.
        default:            nxt_st.rresp      = dea_pkg::RESP_SLVERR;
      endcase
    end

    // Register write once both halves are held.
    if (wr_go) begin
      nxt_st.aw_held = 1'b0;
      nxt_st.w_held  = 1'b0;
      nxt_st.bvalid  = 1'b1;
      nxt_st.bresp   = dea_pkg::RESP_OKAY;
      // [R21] Off-sequence access cancels unlock.
      nxt_st.lock    = dea_pkg::DEA_LK_IDLE;
      nxt_st.gap     = '0;
      case (st_ff.aw_addr)
        // [R5] Software write; the fetch is the only other path.
        dea_pkg::ADDR_BYTE: begin
          if (st_ff.w_lane) begin
            nxt_st.byte_reg = st_ff.w_data;
          end
        end
        // Location register: plain software register.
        dea_pkg::ADDR_LOC: begin
          if (st_ff.w_lane) begin
            nxt_st.loc_reg = st_ff.w_data;
          end
        end
        dea_pkg::ADDR_CTRL: begin
          if (st_ff.w_lane) begin
            // [R11] Permit follows software writes.
            nxt_st.permit = st_ff.w_data[dea_pkg::CTRL_PERMIT];
            // Abort is cleared by writing zero once software has seen it.
            nxt_st.abort  = st_ff.w_data[dea_pkg::CTRL_ABORT];
            // A written zero leaves both trigger bits alone.
            // [R4] Only ones take effect.
            if (st_ff.w_data[dea_pkg::CTRL_RD]) begin
              nxt_st.rd = 1'b1;
              ctl_rd_go = 1'b1;
            end
            // [R7] Start after both keys.
            // [R10] Start needs permit.
            if (st_ff.w_data[dea_pkg::CTRL_WR] && st_ff.lock == dea_pkg::DEA_LK_KEY2 &&
                st_ff.permit && !st_ff.wr) begin
              nxt_st.wr        = 1'b1;
              nxt_st.store_cnt = STORE_LOAD;
              nxt_st.st_loc    = st_ff.loc_reg;
              nxt_st.st_byte   = st_ff.byte_reg;
            end
          end
        end
        // The key port stores nothing; it only steps the tracker.
        dea_pkg::ADDR_KEY: begin
          // [R8] Keys must come in exact order.
          // A wrong value leaves the tracker idle, as cleared above.
          if (st_ff.w_lane && st_ff.lock == dea_pkg::DEA_LK_IDLE && st_ff.w_data == dea_pkg::KEY_FIRST) begin
            nxt_st.lock = dea_pkg::DEA_LK_KEY1;
          end else if (st_ff.w_lane && st_ff.lock == dea_pkg::DEA_LK_KEY1 &&
                       st_ff.w_data == dea_pkg::KEY_SECOND) begin
            nxt_st.lock = dea_pkg::DEA_LK_KEY2;
          end
        end
        // Flag register: software clears done by writing zero.
        dea_pkg::ADDR_FLAG: begin
          if (st_ff.w_lane) begin
            nxt_st.done = st_ff.w_data[dea_pkg::FLAG_DONE];
          end
        end
        // Unmapped write: error answer; only the unlock is cancelled.
        default: nxt_st.bresp = dea_pkg::RESP_SLVERR;
      endcase
    end

    // [R2] Fetch addressed byte.
    // [R3] Trigger lasts one cycle.
    if (st_ff.rd) begin
      nxt_st.byte_reg = mem_rd;
      nxt_st.rd       = 1'b0;
    end

    // Running store counts down; permit plays no part here.
    // [R12] Store ignores permit changes.
    // [R18] Start bit holds until the end.
    if (st_ff.wr) begin
      nxt_st.wr        = 1'b1;
      nxt_st.store_cnt = st_ff.store_cnt - 1'b1;
      // [R13] Finish clears start, sets done.
      if (st_ff.store_cnt == dea_pkg::CNT_W'(1)) begin
        nxt_st.wr   = 1'b0;
        // Set last, so it wins over a software clear in the same cycle.
        nxt_st.done = 1'b1;
        // The array takes the latched byte on the same edge.
        mem_we      = 1'b1;
      end
    end

    // Warm reset: trigger and permit bits to reset values, data registers unchanged.
    if (warm_rst) begin
      // [R19] Interrupted store flags abort.
      // Set here, after the register writes, so it wins over software.
      if (st_ff.wr) begin
        nxt_st.abort = 1'b1;
      end
      // A store cut short never reaches the array.
      mem_we           = 1'b0;
      nxt_st.wr        = 1'b0;
      nxt_st.rd        = 1'b0;
      nxt_st.permit    = 1'b0;
      nxt_st.lock      = dea_pkg::DEA_LK_IDLE;
      nxt_st.store_cnt = '0;
      // Pending bus state is dropped; the master must retry.
      nxt_st.aw_held   = 1'b0;
      nxt_st.w_held    = 1'b0;
      nxt_st.bvalid    = 1'b0;
      nxt_st.rvalid    = 1'b0;
    end

    // Ready outputs are registered from the next held state.
    // They stay low while an answer waits, so one transfer per direction runs at a time.
    nxt_st.awready = !nxt_st.aw_held && !nxt_st.bvalid && !warm_rst;
    nxt_st.wready  = !nxt_st.w_held && !nxt_st.bvalid && !warm_rst;
    nxt_st.arready = !nxt_st.rvalid && !warm_rst;
  end

  // State register with synchronous power-on reset.
  // Power-on reset clears every field, readies included.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Array write at store completion from the latched location and byte.
  // The array has no reset, so its contents survive both resets.
  always_ff @(posedge core_clk) begin
    if (mem_we) begin
      mem_q[st_ff.st_loc] <= st_ff.st_byte;
    end
  end

  // Outputs come straight from the state register.
  assign s_axi_awready = st_ff.awready;
  assign s_axi_wready  = st_ff.wready;
  assign s_axi_bvalid  = st_ff.bvalid;
  assign s_axi_bresp   = st_ff.bresp;
  assign s_axi_arready = st_ff.arready;
  assign s_axi_rvalid  = st_ff.rvalid;
  assign s_axi_rdata   = st_ff.rdata;
  assign s_axi_rresp   = st_ff.rresp;
  // The store start bit doubles as the busy indication.
  assign store_busy    = st_ff.wr;

  // Checks on the controller's own behaviour.
  default clocking dea_cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // [R2] Fetch lands next cycle.
  a_read_fetch_data: assert property (st_ff.rd && !warm_rst |=> st_ff.byte_reg == $past(mem_rd)) // [R2]
    else $error("byte register did not take the addressed byte");
  // [R3] Trigger self clears.
  a_read_one_cycle: assert property (st_ff.rd |=> !st_ff.rd) // [R3]
    else $error("read trigger stayed set longer than one cycle");
  // [R4] Writing one sets trigger.
  a_read_trigger_set: assert property (ctl_rd_go && !warm_rst |=> st_ff.rd ##1 !st_ff.rd) // [R4]
    else $error("read trigger write did not take effect");
  // [R5] Byte register holds.
  a_byte_reg_hold: assert property (!st_ff.rd && !(wr_go && st_ff.aw_addr == dea_pkg::ADDR_BYTE)
                                    |=> $stable(st_ff.byte_reg)) // [R5]
    else $error("byte register changed without a read or write");
  // [R7] Store starts only after both keys.
  a_store_after_keys: assert property ($rose(st_ff.wr) |-> $past(st_ff.lock) == dea_pkg::DEA_LK_KEY2) // [R7]
    else $error("store started without the unlock sequence");
  // [R10] Store starts only with permit.
  a_store_permit: assert property ($rose(st_ff.wr) |-> $past(st_ff.permit)) // [R10]
    else $error("store started while permit was clear");
  // [R11] Permit changes only by software or reset.
  a_permit_sw_only: assert property (!(wr_go && st_ff.aw_addr == dea_pkg::ADDR_CTRL) && !warm_rst
                                     |=> $stable(st_ff.permit)) // [R11]
    else $error("permit bit changed without a software write");
  // [R13] Completion clears start and sets done.
  a_store_done: assert property (st_ff.wr && st_ff.store_cnt == 1 && !warm_rst
                                 |=> !st_ff.wr && st_ff.done) // [R13]
    else $error("store completion not signalled");
  // [R18] Start bit cannot be cleared early.
  a_store_no_cut: assert property (st_ff.wr && st_ff.store_cnt > 1 && !warm_rst |=> st_ff.wr) // [R18]
    else $error("store ended before its count ran out");
  // [R19] Warm reset during store flags abort.
  a_store_abort: assert property (st_ff.wr && warm_rst |=> st_ff.abort && !st_ff.wr && $stable(st_ff.loc_reg)) // [R19]
    else $error("interrupted store not flagged");
  // [R21] Read access cancels unlock.
  a_lock_cancel: assert property (ar_go |=> st_ff.lock == dea_pkg::DEA_LK_IDLE) // [R21]
    else $error("unlock tracker survived another access");

  // Main scenarios: fetch, finished store, interrupted store, late key, permit dropped mid store.
  c_read_done: cover property (st_ff.rd ##1 st_ff.rvalid [*1]);
  c_store_done: cover property (st_ff.wr ##1 !st_ff.wr && st_ff.done);
  c_store_abort: cover property (st_ff.wr && warm_rst);
  c_unlock_late: cover property (st_ff.lock != dea_pkg::DEA_LK_IDLE && st_ff.gap == GAP_LAST);
  c_permit_drop: cover property (st_ff.wr && !st_ff.permit);

endmodule : dea_ctrl

/* File: verification/tb_top.sv */
// Self-checking bench for the data store access controller over its register bus.
`timescale 1ns/10ps
module tb_top;
  logic        core_clk;       // Bench clock, 40 ns period.
  logic        rst;            // Power-on reset, active high.
  logic        warm_rst;       // Warm reset, active high.
  logic        awvalid, wvalid, bready, arvalid, rready;  // Master handshakes.
  logic        awready, wready, bvalid, arready, rvalid;  // Slave handshakes.
  logic [11:0] awaddr, araddr; // Byte addresses.
  logic [31:0] wdata, rdata;   // Bus data.
  logic [3:0]  wstrb;          // Byte lanes.
  logic [1:0]  bresp, rresp;   // Bus answers.
  logic        store_busy;     // Store in progress.
  logic [31:0] rd_val;         // Last read word.
  logic [1:0]  rsp;            // Last answer code.
  int          failures, n_compared, cyc;

  // Small store time keeps the run short.
  dea_ctrl #(.STORE_CYCLES(40), .DEPTH(256)) u_dut (
    .core_clk(core_clk), .rst(rst), .warm_rst(warm_rst),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .store_busy(store_busy));

  // Clock generator.
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  // Cuts a hang short.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      failures = failures + 1;
      finish_test();
    end
  end

  // Compares one word and counts the result.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One bus write; address and data are released as each is taken.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    awaddr <= a; wdata <= {24'h0, d};
    do begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (awvalid && !awready || wvalid && !wready);
    while (!bvalid) @(posedge core_clk);
    // bready stays high, so back-to-back writes never drop and raise it in one step.
    rsp = bresp;
  endtask : wr

  // One bus read; the word lands in rd_val.
  task automatic rd(input logic [11:0] a);
    arvalid <= 1'b1; rready <= 1'b1; araddr <= a;
    do @(posedge core_clk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge core_clk);
    rd_val = rdata;
    // rready stays high, so back-to-back reads never drop and raise it in one step.
    rsp = rresp;
  endtask : rd

  // Loads location and byte, then runs the unlock and start steps.
  task automatic store(input logic [7:0] l, input logic [7:0] b);
    wr(dea_pkg::ADDR_LOC, l);
    wr(dea_pkg::ADDR_BYTE, b);
    wr(dea_pkg::ADDR_KEY, dea_pkg::KEY_FIRST);
    wr(dea_pkg::ADDR_KEY, dea_pkg::KEY_SECOND);
    wr(dea_pkg::ADDR_CTRL, 8'h06);
  endtask : store

  // Fetches one array byte through the read trigger.
  task automatic fetch(input logic [7:0] l);
    wr(dea_pkg::ADDR_LOC, l);
    // Permit is written back as one, so a fetch leaves it set.
    wr(dea_pkg::ADDR_CTRL, 8'h05);
    rd(dea_pkg::ADDR_BYTE);
  endtask : fetch

  // Main sequence.
  initial begin
    failures = 0; n_compared = 0;
    rst = 1'b1; warm_rst = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = 12'h000; araddr = 12'h000;
    wdata = 32'h0000_0000; wstrb = 4'h1;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    rd(dea_pkg::ADDR_CTRL); chk(rd_val, 32'h0000_0000);  // permit clear
    wr(dea_pkg::ADDR_KEY, 8'h55);
    rd(dea_pkg::ADDR_KEY); chk(rd_val, 32'h0000_0000);   // key reads zero
    rd(12'h000); chk({30'h0, rsp}, {30'h0, dea_pkg::RESP_SLVERR});
    wr(12'h000, 8'h12); chk({30'h0, rsp}, {30'h0, dea_pkg::RESP_SLVERR});
    // Store attempt without permit is refused; permit set in the same write does not count.
    store(8'h05, 8'h3C); chk({31'h0, store_busy}, 32'h0);  // no permit
    rd(dea_pkg::ADDR_CTRL); chk(rd_val, 32'h0000_0004);    // start bit stays clear
    // Proper store with permit.
    wr(dea_pkg::ADDR_CTRL, 8'h04);
    store(8'h05, 8'hA5); chk({31'h0, store_busy}, 32'h1);  // store begins
    wr(dea_pkg::ADDR_CTRL, 8'h04);
    rd(dea_pkg::ADDR_CTRL); chk(rd_val, 32'h0000_0006);    // start not cleared
    while (store_busy) @(posedge core_clk);
    rd(dea_pkg::ADDR_CTRL); chk(rd_val, 32'h0000_0004);    // start clear, permit kept
    rd(dea_pkg::ADDR_FLAG); chk(rd_val, 32'h0000_0001);    // done set
    wr(dea_pkg::ADDR_FLAG, 8'h00);                         // software clears done
    rd(dea_pkg::ADDR_FLAG); chk(rd_val, 32'h0000_0000);    // done cleared
    fetch(8'h05); chk(rd_val, 32'h0000_00A5);              // fetched byte
    rd(dea_pkg::ADDR_CTRL); chk(rd_val, 32'h0000_0004);    // trigger cleared
    wr(dea_pkg::ADDR_LOC, 8'h09);
    rd(dea_pkg::ADDR_BYTE); chk(rd_val, 32'h0000_00A5);    // byte held
    // Broken unlock attempts with permit set: wrong order, slow step, stray access.
    wr(dea_pkg::ADDR_BYTE, 8'h11);
    wr(dea_pkg::ADDR_KEY, 8'hAA); wr(dea_pkg::ADDR_KEY, 8'h55); wr(dea_pkg::ADDR_CTRL, 8'h06);
    chk({31'h0, store_busy}, 32'h0);                       // wrong order
    wr(dea_pkg::ADDR_KEY, 8'h55); repeat (20) @(posedge core_clk);
    wr(dea_pkg::ADDR_KEY, 8'hAA); wr(dea_pkg::ADDR_CTRL, 8'h06);
    chk({31'h0, store_busy}, 32'h0);                       // slow step
    wr(dea_pkg::ADDR_KEY, 8'h55); rd(dea_pkg::ADDR_FLAG);
    wr(dea_pkg::ADDR_KEY, 8'hAA); wr(dea_pkg::ADDR_CTRL, 8'h06);
    chk({31'h0, store_busy}, 32'h0);                       // stray read
    fetch(8'h05); chk(rd_val, 32'h0000_00A5);              // location 05 unchanged
    // Clearing permit mid store does not stop it.
    store(8'h06, 8'h3C);
    wr(dea_pkg::ADDR_CTRL, 8'h00); chk({31'h0, store_busy}, 32'h1);  // store runs on
    while (store_busy) @(posedge core_clk);
    fetch(8'h06); chk(rd_val, 32'h0000_003C);              // byte stored, read back
    wr(dea_pkg::ADDR_FLAG, 8'h00);                         // software clears done
    // Warm reset in mid store.
    wr(dea_pkg::ADDR_CTRL, 8'h04);
    store(8'h07, 8'h77);
    warm_rst <= 1'b1;
    @(posedge core_clk);
    warm_rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk({31'h0, store_busy}, 32'h0);                       // store stopped
    rd(dea_pkg::ADDR_CTRL); chk(rd_val, 32'h0000_0008);    // abort set
    rd(dea_pkg::ADDR_LOC); chk(rd_val, 32'h0000_0007);     // location kept
    rd(dea_pkg::ADDR_BYTE); chk(rd_val, 32'h0000_0077);    // byte kept
    finish_test();
  end
endmodule : tb_top
